// >>> bsr_top.sv
// The strobed register port was decided locally.
`timescale 1ns/1ps

// Contract
// - Bits 15:14 of both registers mirror balancing state; 00 disabled, 01 running.
// - Mirror shows 10 after normal finish by threshold or expiration.
// - Mirror shows 11 after thermal, timeout or calibration halt.
// - Bits 13:0 hold per-cell undervoltage exit; set bit stops that cell.
// - Undervoltage bits clear only on mode disable or new balancing start.
// - Unsupported cells end balancing immediately with their undervoltage bit set; here only while measure enable is 11.
// - Bit 13 of data register mirrors data-ready after results land.
// - All result words and min, max, total update in one transfer.
// - Writing 0 clears data-ready; writing 1 leaves it unchanged.
// - Data-ready mirror equals the scan configuration data-ready bit.
// - Strobe bit 0 copies filter outputs to data registers, then sets ready.
// - Transfer strobe self-clears and always reads back as 0.
// - Strobe ignored in manual or disabled mode or measure enable 0x.
// - Measure enable 0x off, 10 measure only, 11 measure and check.

module bsr_top #(
  parameter int CELLS = 14,
  parameter int WORDS = 17
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Register port
  input wire logic [bsr_pkg::ADDR_W-1:0] i_addr,
  input wire logic [bsr_pkg::WORD_W-1:0] i_wdata,
  input wire logic i_we,
  input wire logic i_re,
  output logic [bsr_pkg::WORD_W-1:0] o_rdata,
  // Balancing engine and configuration
  input wire bsr_pkg::bsr_engine_t i_engine,
  input wire logic [2:0] i_balance_mode_field,
  input wire logic [1:0] i_balance_measure_enable,
  input wire bsr_pkg::bsr_cell_cfg_t i_cell_cfg,
  input wire bsr_pkg::bsr_uv_check_t i_uv_check,
  output logic [CELLS-1:0] o_cell_stop,
  output logic [1:0] o_balance_state,
  // Scan configuration data-ready shared flag
  input wire logic i_scan_ready_write,
  input wire logic i_scan_ready_wdata,
  input wire logic i_scan_load,
  input wire logic [WORDS*bsr_pkg::WORD_W-1:0] i_scan_results,
  output logic o_results_ready_flag,
  // Filter outputs and result readout
  input wire logic [WORDS*bsr_pkg::WORD_W-1:0] i_filter_results,
  input wire logic i_result_rd,
  input wire logic [bsr_pkg::IDX_W-1:0] i_result_idx,
  output logic [bsr_pkg::WORD_W-1:0] o_result_data
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  generate
    if (CELLS != bsr_pkg::CELLS) begin : g_chk_cells
      $error("bsr_top: cell count must match the 14-bit status field.");
    end
    if (WORDS != bsr_pkg::RESULT_WORDS) begin : g_chk_words
      $error("bsr_top: result word count must match the package.");
    end
    if (bsr_pkg::WORD_W != 16) begin : g_chk_word_w
      $error("bsr_top: register words are built as 16-bit fields.");
    end
    if (bsr_pkg::ADDR_W != 8) begin : g_chk_addr_w
      $error("bsr_top: register offsets are 8-bit constants.");
    end
    if (bsr_pkg::STATE_MSB != bsr_pkg::WORD_W - 1) begin : g_chk_state_msb
      $error("bsr_top: state mirror must sit in the top two bits.");
    end
    if (bsr_pkg::STATE_LSB != bsr_pkg::STATE_MSB - 1) begin : g_chk_state_lsb
      $error("bsr_top: state mirror must be two bits wide.");
    end
    if (CELLS != bsr_pkg::STATE_LSB) begin : g_chk_uv_field
      $error("bsr_top: undervoltage bits must fill the field below the state mirror.");
    end
    if (bsr_pkg::READY_BIT != bsr_pkg::STATE_LSB - 1) begin : g_chk_ready
      $error("bsr_top: data-ready bit must sit just below the state mirror.");
    end
    if (bsr_pkg::STROBE_BIT >= bsr_pkg::READY_BIT) begin : g_chk_strobe
      $error("bsr_top: strobe bit must sit below the data-ready bit.");
    end
    if ((1 << bsr_pkg::IDX_W) < WORDS) begin : g_chk_idx
      $error("bsr_top: result index too narrow for the word count.");
    end
    if (bsr_pkg::ADDR_UV_STATUS == bsr_pkg::ADDR_DATA_CTRL) begin : g_chk_addr
      $error("bsr_top: the two register offsets must differ.");
    end
    if (bsr_pkg::MODE_DISABLED == bsr_pkg::MODE_MANUAL) begin : g_chk_mode
      $error("bsr_top: disabled and manual mode codes must differ.");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  wire sel_uv = i_addr == bsr_pkg::ADDR_UV_STATUS;
  wire sel_data = i_addr == bsr_pkg::ADDR_DATA_CTRL;
  wire wr_data = i_we && sel_data;
  wire rd_uv = i_re && sel_uv;
  wire rd_data = i_re && sel_data;

  // ----------------------------------------------------------------
  // Write field decode
  // ----------------------------------------------------------------
  // Writes to the status register have no target and are dropped on purpose.
  wire wr_strobe = wr_data && i_wdata[bsr_pkg::STROBE_BIT];
  wire wr_ready_zero = wr_data && !i_wdata[bsr_pkg::READY_BIT];

  // ----------------------------------------------------------------
  // Balancing state mirror
  // ----------------------------------------------------------------
  bsr_pkg::bsr_state_t state;
  bsr_pkg::bsr_state_t next_state;
  logic [1:0] next_code;

  wire halt_event = i_engine.thermal_alert || i_engine.timeout_alert || i_engine.calibration_alert;
  wire start_ok = i_engine.start && (i_balance_mode_field != bsr_pkg::MODE_DISABLED);

  always_comb begin
    next_state = state;
    if (i_engine.mode_off_write) begin
      next_state = bsr_pkg::BSR_IDLE;
    end else begin
      case (state)
        bsr_pkg::BSR_IDLE: begin
          if (start_ok) begin
            next_state = bsr_pkg::BSR_ACTIVE;
          end
        end
        bsr_pkg::BSR_ACTIVE: begin
          // A halt outranks a normal finish seen in the same cycle.
          if (halt_event) begin
            next_state = bsr_pkg::BSR_HALTED;
          end else if (i_engine.done_normal) begin
            next_state = bsr_pkg::BSR_DONE;
          end
        end
        bsr_pkg::BSR_DONE, bsr_pkg::BSR_HALTED: begin
          if (start_ok) begin
            next_state = bsr_pkg::BSR_ACTIVE;
          end
        end
        default: begin
          next_state = bsr_pkg::BSR_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    case (next_state)
      bsr_pkg::BSR_ACTIVE: next_code = bsr_pkg::CODE_ACTIVE;
      bsr_pkg::BSR_DONE: next_code = bsr_pkg::CODE_DONE;
      bsr_pkg::BSR_HALTED: next_code = bsr_pkg::CODE_HALTED;
      default: next_code = bsr_pkg::CODE_DISABLED;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= bsr_pkg::BSR_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // The code is loaded from next_state, so the mirror never lags the state.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_balance_state <= bsr_pkg::CODE_DISABLED;
    end else begin
      o_balance_state <= next_code;
    end
  end

  // ----------------------------------------------------------------
  // Per-cell undervoltage exit bits
  // ----------------------------------------------------------------
  // Checking runs only while balancing is active with measure enable 11;
  // with 10 measurements run but no cell is ever stopped by threshold.
  wire check_on = (state == bsr_pkg::BSR_ACTIVE) &&
                  (i_balance_measure_enable == bsr_pkg::MEAS_CHECK);
  wire uv_clear = i_engine.start || i_engine.mode_off_write;
  logic [CELLS-1:0] uv_bits;
  logic [CELLS-1:0] next_uv_bits;

  generate
    for (genvar n = 0; n < CELLS; n++) begin : g_cell
      // A cell that is not switchable, not measured or not unipolar cannot be checked.
      wire no_switch = !i_cell_cfg.switch_enable[n];
      wire no_measure = !i_cell_cfg.measure_enable[n];
      wire bipolar = i_cell_cfg.polarity_select[n];
      wire unsupported = no_switch || no_measure || bipolar;
      wire below = i_uv_check.valid && i_uv_check.below[n];
      wire set_bit = check_on && i_cell_cfg.balancing[n] && (below || unsupported);
      // Set wins over a clear arriving in the same cycle.
      assign next_uv_bits[n] = set_bit ? 1'b1 : (uv_clear ? 1'b0 : uv_bits[n]);
    end
  endgenerate

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      uv_bits <= bsr_pkg::UV_STATUS_RST[CELLS-1:0];
    end else begin
      uv_bits <= next_uv_bits;
    end
  end

  // A separate copy keeps the stop lines a plain flop output.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_cell_stop <= '0;
    end else begin
      o_cell_stop <= next_uv_bits;
    end
  end

  // ----------------------------------------------------------------
  // Transfer strobe and result snapshot
  // ----------------------------------------------------------------
  wire mode_auto = (i_balance_mode_field != bsr_pkg::MODE_DISABLED) &&
                   (i_balance_mode_field != bsr_pkg::MODE_MANUAL);
  wire meas_on = i_balance_measure_enable[1];
  wire strobe_go = wr_strobe && mode_auto && meas_on;
  // The filter path wins if a scan load lands in the same cycle; the scan
  // engine's result is then dropped, which keeps the copy a single event.
  wire snap_load = strobe_go || i_scan_load;
  wire [WORDS*bsr_pkg::WORD_W-1:0] snap_src = strobe_go ? i_filter_results : i_scan_results;
  wire snap_done;

  bsr_snapshot #(
    .WORDS(WORDS),
    .W(bsr_pkg::WORD_W),
    .IDX_W(bsr_pkg::IDX_W)
  ) u_snapshot (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_load(snap_load),
    .i_data(snap_src),
    .i_rd(i_result_rd),
    .i_rd_idx(i_result_idx),
    .o_rd_data(o_result_data),
    .o_load_done(snap_done)
  );

  // ----------------------------------------------------------------
  // Shared data-ready flag
  // ----------------------------------------------------------------
  wire scan_ready_clear = i_scan_ready_write && !i_scan_ready_wdata;
  wire ready_clear = wr_ready_zero || scan_ready_clear;
  wire next_ready = snap_done ? 1'b1 : (ready_clear ? 1'b0 : o_results_ready_flag);

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_results_ready_flag <= bsr_pkg::DATA_CTRL_RST[bsr_pkg::READY_BIT];
    end else begin
      o_results_ready_flag <= next_ready;
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  wire [15:0] uv_word = {o_balance_state, uv_bits};
  // Strobe and unused bits are constant zero, so nothing can be stored there.
  wire [15:0] data_word = {o_balance_state, o_results_ready_flag, 13'h0000};
  wire [15:0] next_rdata = rd_uv ? uv_word :
                           rd_data ? data_word : bsr_pkg::RDATA_RST;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= bsr_pkg::RDATA_RST;
    end else begin
      o_rdata <= next_rdata;
    end
  end

endmodule

// >>> bsr_pkg.sv
package bsr_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int CELLS = 14;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 8;
  localparam int RESULT_WORDS = 17;
  localparam int IDX_W = 5;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_UV_STATUS = 8'h82;
  localparam logic [7:0] ADDR_DATA_CTRL = 8'h83;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int STATE_MSB = 15;
  localparam int STATE_LSB = 14;
  localparam int READY_BIT = 13;
  localparam int STROBE_BIT = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] UV_STATUS_RST = 16'h0000;
  localparam logic [15:0] DATA_CTRL_RST = 16'h0000;
  localparam logic [15:0] RDATA_RST = 16'h0000;

  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  localparam logic [1:0] CODE_DISABLED = 2'h0;
  localparam logic [1:0] CODE_ACTIVE = 2'h1;
  localparam logic [1:0] CODE_DONE = 2'h2;
  localparam logic [1:0] CODE_HALTED = 2'h3;
  localparam logic [2:0] MODE_DISABLED = 3'h0;
  localparam logic [2:0] MODE_MANUAL = 3'h1;
  localparam logic [1:0] MEAS_CHECK = 2'h3;

  typedef enum logic [3:0] {
    BSR_IDLE = 4'h1,
    BSR_ACTIVE = 4'h2,
    BSR_DONE = 4'h4,
    BSR_HALTED = 4'h8
  } bsr_state_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic start;
    logic mode_off_write;
    logic done_normal;
    logic thermal_alert;
    logic timeout_alert;
    logic calibration_alert;
  } bsr_engine_t;

  typedef struct packed {
    logic [CELLS-1:0] switch_enable;
    logic [CELLS-1:0] measure_enable;
    logic [CELLS-1:0] polarity_select;
    logic [CELLS-1:0] balancing;
  } bsr_cell_cfg_t;

  typedef struct packed {
    logic valid;
    logic [CELLS-1:0] below;
  } bsr_uv_check_t;

endpackage

// >>> bsr_snapshot.sv
`timescale 1ns/1ps

module bsr_snapshot #(
  parameter int WORDS = 17,
  parameter int W = 16,
  parameter int IDX_W = 5
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Load side
  input wire logic i_load,
  input wire logic [WORDS*W-1:0] i_data,
  // Read side
  input wire logic i_rd,
  input wire logic [IDX_W-1:0] i_rd_idx,
  output logic [W-1:0] o_rd_data,
  output logic o_load_done
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Every word loads on the same edge, so a reader never sees a mix of
  // old and new results.
  logic [W-1:0] mem [WORDS];

  generate
    if ((1 << IDX_W) < WORDS) begin : g_chk
      $error("bsr_snapshot: index too narrow for word count.");
    end
    for (genvar g = 0; g < WORDS; g++) begin : g_word
      always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          mem[g] <= '0;
        end else if (i_load) begin
          mem[g] <= i_data[g*W +: W];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Registered read
  // ----------------------------------------------------------------
  wire idx_ok = 32'(i_rd_idx) < WORDS;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rd_data <= '0;
      o_load_done <= 1'b0;
    end else begin
      o_rd_data <= (i_rd && idx_ok) ? mem[i_rd_idx] : '0;
      o_load_done <= i_load;
    end
  end

endmodule

// >>> bsr_top_chk.sv
`timescale 1ns/1ps

module bsr_top_chk #(
  parameter int CELLS = 14,
  parameter int WORDS = 17
) (
  // Clock and reset
  input logic i_clk,
  input logic i_rstn,
  // Register port
  input logic [7:0] i_addr,
  input logic [15:0] i_wdata,
  input logic i_we,
  input logic i_re,
  input logic [15:0] o_rdata,
  // Engine and results
  input bsr_pkg::bsr_engine_t i_engine,
  input logic [2:0] i_balance_mode_field,
  input logic [1:0] i_balance_measure_enable,
  input logic i_scan_load,
  input logic [CELLS-1:0] o_cell_stop,
  input logic [1:0] o_balance_state,
  input logic o_results_ready_flag
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic ld_ev;
  logic alert;
  logic calm;
  logic hot;
  assign ld_ev = i_scan_load | (i_we && i_addr == 8'h83 && i_wdata[0] && i_balance_mode_field > 3'h1
    && i_balance_measure_enable[1]);
  assign alert = i_engine.thermal_alert | i_engine.timeout_alert | i_engine.calibration_alert;
  assign calm = !i_engine.start && !i_engine.mode_off_write;
  // Bits may only be set while running with the threshold check on.
  assign hot = o_balance_state == 2'h1 && i_balance_measure_enable == 2'h3;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  sequence s_read(a);
    i_re && i_addr == a;
  endsequence
  sequence s_load;
    ld_ev;
  endsequence

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  chk_rdata_idle: assert property (!i_re |=> o_rdata == 16'h0)
    else $error("read data not zero outside a read");
  chk_status_read: assert property (s_read(8'h82) |=> o_rdata == {$past(o_balance_state), $past(o_cell_stop)})
    else $error("status register readback wrong");
  chk_data_read: assert property (s_read(8'h83) |=> o_rdata == {$past(o_balance_state),
    $past(o_results_ready_flag), 13'h0})
    else $error("data register readback wrong");
  chk_start_active: assert property (i_engine.start && !i_engine.mode_off_write && !alert && !i_engine.done_normal
    && i_balance_mode_field != 3'h0 |=> o_balance_state == 2'h1)
    else $error("start did not enter running state");
  chk_done_normal: assert property (o_balance_state == 2'h1 && i_engine.done_normal && !alert && calm
    |=> o_balance_state == 2'h2)
    else $error("normal finish not reported");
  chk_alert_halt: assert property (o_balance_state == 2'h1 && alert && calm |=> o_balance_state == 2'h3)
    else $error("halt not reported");
  chk_mode_off: assert property (i_engine.mode_off_write |=> o_balance_state == 2'h0)
    else $error("disable did not return state to zero");
  chk_uv_clear: assert property ((i_engine.start || i_engine.mode_off_write) && !hot |=> o_cell_stop == '0)
    else $error("undervoltage bits not cleared");
  chk_uv_sticky: assert property (calm |=> (o_cell_stop & $past(o_cell_stop)) == $past(o_cell_stop))
    else $error("undervoltage bit cleared without cause");
  chk_uv_quiet: assert property (!hot |=> (o_cell_stop & ~$past(o_cell_stop)) == '0)
    else $error("undervoltage bit set while not checking");
  chk_ready_set: assert property (s_load |-> ##2 o_results_ready_flag)
    else $error("data ready not set after transfer");
  chk_ready_cause: assert property ($rose(o_results_ready_flag) |-> $past(ld_ev, 2))
    else $error("data ready rose without accepted transfer");
endmodule

bind bsr_top bsr_top_chk #(.CELLS(CELLS), .WORDS(WORDS)) u_bsr_top_chk (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_we(i_we), .i_re(i_re),
  .o_rdata(o_rdata), .i_engine(i_engine), .i_balance_mode_field(i_balance_mode_field),
  .i_balance_measure_enable(i_balance_measure_enable), .i_scan_load(i_scan_load),
  .o_cell_stop(o_cell_stop), .o_balance_state(o_balance_state), .o_results_ready_flag(o_results_ready_flag));

// >>> tb_top.sv
`timescale 1ns/1ps

module tb_top;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic i_clk = 0, i_rstn = 0, i_we = 0, i_re = 0, i_result_rd = 0;
  logic i_scan_ready_write = 0, i_scan_ready_wdata = 0, i_scan_load = 0;
  logic [7:0] i_addr = 0;
  logic [15:0] i_wdata = 0;
  logic [4:0] i_result_idx = 0;
  logic [2:0] i_balance_mode_field = 0;
  logic [1:0] i_balance_measure_enable = 0;
  bsr_pkg::bsr_engine_t i_engine = '0;
  bsr_pkg::bsr_cell_cfg_t i_cell_cfg = '0;
  bsr_pkg::bsr_uv_check_t i_uv_check = '0;
  logic [271:0] i_scan_results = '0, i_filter_results = '0, snap;
  logic [15:0] o_rdata, o_result_data;
  logic [13:0] o_cell_stop, uv, bal;
  logic [1:0] o_balance_state;
  logic o_results_ready_flag;
  logic ok;
  int miscompares = 0, checked = 0, cyc = 0;

  bsr_top u_bsr_top (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_we(i_we),
    .i_re(i_re), .o_rdata(o_rdata), .i_engine(i_engine), .i_balance_mode_field(i_balance_mode_field),
    .i_balance_measure_enable(i_balance_measure_enable), .i_cell_cfg(i_cell_cfg), .i_uv_check(i_uv_check),
    .o_cell_stop(o_cell_stop), .o_balance_state(o_balance_state), .i_scan_ready_write(i_scan_ready_write),
    .i_scan_ready_wdata(i_scan_ready_wdata), .i_scan_load(i_scan_load), .i_scan_results(i_scan_results),
    .o_results_ready_flag(o_results_ready_flag), .i_filter_results(i_filter_results),
    .i_result_rd(i_result_rd), .i_result_idx(i_result_idx), .o_result_data(o_result_data));

  always #4 i_clk = ~i_clk;

  // The whole run needs under 1000 cycles, so this ceiling only trips on a hang.
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // Tasks and functions
  // ----------------------------------------------------------------
  task automatic chk_w(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk_b(input logic g, input logic e);
    chk_w({15'h0, g}, {15'h0, e});
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_we <= 1'b1;
    @(posedge i_clk);
    i_we <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge i_clk);
    i_addr <= a;
    i_re <= 1'b1;
    @(posedge i_clk);
    i_re <= 1'b0;
    #1;
    chk_w(o_rdata, e);
  endtask

  // Word 17 lies past the last result and must read as zero.
  task automatic rres(input logic [271:0] v);
    for (int k = 0; k < 18; k++) begin
      @(posedge i_clk);
      i_result_idx <= 5'(k);
      i_result_rd <= 1'b1;
      @(posedge i_clk);
      i_result_rd <= 1'b0;
      #1;
      chk_w(o_result_data, k < 17 ? v[16*k+:16] : 16'h0);
    end
  endtask

  task automatic pulse(input logic [5:0] e);
    @(posedge i_clk);
    i_engine <= e;
    @(posedge i_clk);
    i_engine <= '0;
  endtask

  function automatic logic [271:0] rnd();
    logic [271:0] r;
    for (int k = 0; k < 17; k++) r[16*k+:16] = 16'($urandom);
    return r;
  endfunction

  function automatic logic [15:0] exp83(input logic [1:0] s, input logic r);
    return {s, r, 13'h0};
  endfunction

  task automatic complete_run();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h9327));
    repeat (4) @(posedge i_clk);
    i_rstn <= 1'b1;
    rd(8'h82, 16'h0000);
    rd(8'h83, 16'h0000);
    rd(8'h84, 16'h0000);
    $display("test reset done");
    @(posedge i_clk);
    i_balance_mode_field <= 3'h2;
    i_balance_measure_enable <= 2'h3;
    bal = 14'($urandom) | 14'h1;
    i_cell_cfg <= {{14{1'b1}}, {14{1'b1}}, 14'h0, bal};
    pulse(6'h20);
    rd(8'h82, 16'h4000);
    uv = 14'($urandom);
    @(posedge i_clk);
    i_uv_check <= {1'b1, uv};
    uv = (uv & bal) | 14'h1;
    @(posedge i_clk);
    i_uv_check <= '0;
    i_cell_cfg.polarity_select <= 14'h1;
    @(posedge i_clk);
    i_cell_cfg.polarity_select <= 14'h0;
    rd(8'h82, {2'h1, uv});
    chk_w({2'h0, o_cell_stop}, {2'h0, uv});
    pulse(6'h08);
    rd(8'h82, {2'h2, uv});
    pulse(6'h10);
    rd(8'h82, 16'h0000);
    pulse(6'h20);
    @(posedge i_clk);
    i_uv_check <= {1'b1, 14'h3fff};
    @(posedge i_clk);
    i_uv_check <= '0;
    rd(8'h82, {2'h1, bal});
    pulse(6'h20);
    rd(8'h82, 16'h4000);
    @(posedge i_clk);
    i_balance_measure_enable <= 2'h2;
    i_uv_check <= {1'b1, 14'h3fff};
    @(posedge i_clk);
    i_uv_check <= '0;
    i_balance_measure_enable <= 2'h3;
    rd(8'h82, 16'h4000);
    for (int k = 0; k < 3; k++) begin
      pulse(6'h04 >> k);
      rd(8'h82, 16'hc000);
      chk_w({14'h0, o_balance_state}, 16'h0003);
      pulse(6'h20);
    end
    rd(8'h83, exp83(2'h1, 1'b0));
    $display("test balance state done");
    snap = '0;
    for (int m = 0; m < 4; m++) begin
      for (int e = 0; e < 4; e++) begin
        @(posedge i_clk);
        i_balance_mode_field <= 3'(m);
        i_balance_measure_enable <= 2'(e);
        i_filter_results <= rnd();
        ok = m > 1 && e > 1;
        wr(8'h83, 16'h0001);
        repeat (2) @(posedge i_clk);
        #1;
        chk_b(o_results_ready_flag, ok);
        if (ok) snap = i_filter_results;
        rd(8'h83, exp83(2'h1, ok));
        rres(snap);
        wr(8'h83, 16'h2000);
        rd(8'h83, exp83(2'h1, ok));
        wr(8'h83, 16'h0000);
        rd(8'h83, exp83(2'h1, 1'b0));
      end
    end
    $display("test strobe done");
    @(posedge i_clk);
    i_scan_results <= rnd();
    i_scan_load <= 1'b1;
    @(posedge i_clk);
    i_scan_load <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
    chk_b(o_results_ready_flag, 1'b1);
    rres(i_scan_results);
    @(posedge i_clk);
    i_scan_ready_write <= 1'b1;
    i_scan_ready_wdata <= 1'b0;
    @(posedge i_clk);
    i_scan_ready_write <= 1'b0;
    rd(8'h83, exp83(2'h1, 1'b0));
    $display("test scan transfer done");
    complete_run();
  end
endmodule
